/* File: hw/cmpdc_top.v */
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "cmpdc_regs.vh"
module cmpdc_top #(
  parameter N = `CMPDC_NUM,
  parameter PORT_W = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [N-1:0] raw_compare,
  input wire timer_clk_prescaled,
  input wire [N-1:0] pin_direction_bit,
  input wire [PORT_W-1:0] port_pin_level,
  input wire [PORT_W-1:0] port_analog_select,
  output reg [N-1:0] cmp_pin_out,
  output reg [N-1:0] cmp_pin_oe,
  output reg [N-1:0] cmp_timer_out,
  output reg [N-1:0] core_enable,
  output reg [N-1:0] core_speed,
  output reg [N-1:0] core_hysteresis,
  output reg [3*N-1:0] positive_channel_select,
  output reg [3*N-1:0] negative_channel_select,
  output reg [N-1:0] cmp_irq
);
  reg [7:0] ctrl0 [0:N-1];
  reg [7:0] ctrl1 [0:N-1];
  reg [N-1:0] cmp_irq_flag;
  reg [N-1:0] prev_result;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_have;
  reg w_have;
  wire [N-1:0] cmp_result;
  wire [N-1:0] cmp_out;
  wire wr_go = aw_have & w_have & ~s_axi_bvalid;
  wire wr_lane0 = wr_go & wstrb_q[0];
  wire [N-1:0] rise = cmp_result & ~prev_result;
  wire [N-1:0] fall = ~cmp_result & prev_result;
  reg [N-1:0] edge_hit;
  reg [N-1:0] flag_clr;
  reg [31:0] next_rdata;
  reg rd_hit;
  reg wr_hit;
  integer k;
  integer ke;
  integer kr;
  integer kw;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : ch
      cmpdc_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw_compare(raw_compare[g]),
        .cmp_enable(ctrl0[g][`CMPDC_B_ENABLE]),
        .cmp_invert(ctrl0[g][`CMPDC_B_INVERT]),
        .glitch_filter_enable(ctrl0[g][`CMPDC_B_FILTER]),
        .timer_sync_enable(ctrl0[g][`CMPDC_B_SYNC]),
        .timer_clk_prescaled(timer_clk_prescaled),
        .cmp_result(cmp_result[g]),
        .cmp_out(cmp_out[g])
      );
      always @(posedge aclk) begin
        if (!aresetn) begin
          ctrl0[g] <= `CMPDC_CTRL0_RESET;
          ctrl1[g] <= `CMPDC_CTRL1_RESET;
        end else if (wr_lane0) begin
          if (awaddr_q == `CMPDC_CTRL0_BASE + `CMPDC_STRIDE * g) begin
            ctrl0[g] <= wdata_q[7:0] & `CMPDC_CTRL0_WMASK;
          end
          if (awaddr_q == `CMPDC_CTRL1_BASE + `CMPDC_STRIDE * g) begin
            ctrl1[g] <= wdata_q[7:0];
          end
        end
      end
    end
  endgenerate
  always @* begin
    for (ke = 0; ke < N; ke = ke + 1) begin
      edge_hit[ke] = (rise[ke] & ctrl1[ke][`CMPDC_B_RISE])
        | (fall[ke] & ctrl1[ke][`CMPDC_B_FALL]);
      flag_clr[ke] = wr_lane0 && awaddr_q == `CMPDC_FLAG_ADDR && wdata_q[ke];
    end
  end
  always @* begin
    next_rdata = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == `CMPDC_MIRROR_ADDR) begin
      next_rdata[N-1:0] = cmp_result;
    end else if (s_axi_araddr == `CMPDC_FLAG_ADDR) begin
      next_rdata[N-1:0] = cmp_irq_flag;
    end else if (s_axi_araddr == `CMPDC_PORT_ADDR) begin
      next_rdata[PORT_W-1:0] = port_pin_level & ~port_analog_select;
    end else begin
      rd_hit = 1'b0;
      for (kr = 0; kr < N; kr = kr + 1) begin
        if (s_axi_araddr == `CMPDC_CTRL0_BASE + `CMPDC_STRIDE * kr) begin
          next_rdata[7:0] = ctrl0[kr];
          next_rdata[`CMPDC_B_RESULT] = cmp_result[kr];
          rd_hit = 1'b1;
        end
        if (s_axi_araddr == `CMPDC_CTRL1_BASE + `CMPDC_STRIDE * kr) begin
          next_rdata[7:0] = ctrl1[kr];
          rd_hit = 1'b1;
        end
      end
    end
  end
  always @* begin
    wr_hit = (awaddr_q == `CMPDC_FLAG_ADDR);
    for (kw = 0; kw < N; kw = kw + 1) begin
      if (awaddr_q == `CMPDC_CTRL0_BASE + `CMPDC_STRIDE * kw
        || awaddr_q == `CMPDC_CTRL1_BASE + `CMPDC_STRIDE * kw) begin
        wr_hit = 1'b1;
      end
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMPDC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CMPDC_RESP_OKAY;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      cmp_irq_flag <= {N{1'b0}};
      prev_result <= {N{1'b0}};
      cmp_pin_out <= {N{1'b0}};
      cmp_pin_oe <= {N{1'b0}};
      cmp_timer_out <= {N{1'b0}};
      core_enable <= {N{1'b0}};
      core_speed <= {N{1'b1}};
      core_hysteresis <= {N{1'b0}};
      positive_channel_select <= {3*N{1'b0}};
      negative_channel_select <= {3*N{1'b0}};
      cmp_irq <= {N{1'b0}};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `CMPDC_RESP_OKAY : `CMPDC_RESP_SLVERR;
        aw_have <= 1'b0;
        w_have <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= rd_hit ? `CMPDC_RESP_OKAY : `CMPDC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      prev_result <= cmp_result;
      cmp_irq_flag <= (cmp_irq_flag & ~flag_clr) | edge_hit;
      cmp_irq <= (cmp_irq_flag & ~flag_clr) | edge_hit;
      cmp_timer_out <= cmp_out;
      for (k = 0; k < N; k = k + 1) begin
        cmp_pin_out[k] <= cmp_out[k];
        cmp_pin_oe[k] <= ctrl0[k][`CMPDC_B_OE] & ~pin_direction_bit[k];
        core_enable[k] <= ctrl0[k][`CMPDC_B_ENABLE];
        core_speed[k] <= ctrl0[k][`CMPDC_B_SPEED];
        core_hysteresis[k] <= ctrl0[k][`CMPDC_B_HYST];
        positive_channel_select[3*k +: 3] <= ctrl1[k][`CMPDC_PCH_MSB:`CMPDC_PCH_LSB];
        negative_channel_select[3*k +: 3] <= ctrl1[k][`CMPDC_NCH_MSB:`CMPDC_NCH_LSB];
      end
    end
  end
endmodule

/* File: inc/cmpdc_regs.vh */
// Notes on behaviour
// - enable bit 7 of control 0 turns comparator on; off means core powered down.
// - result bit 6 is 1 when positive exceeds negative, reversed when inverted.
// - output enable routes result to pin, needs direction bit clear, ignores enable.
// - invert bit inverts result for software, pin and downstream logic.
// - filter enable bit passes the result through the glitch filter.
// - speed/power select resets to 1 (fast); 0 selects low power.
// - hysteresis enable bit asks the analog core for hysteresis.
// - sync mode updates timer and pin output on falling timer clock edge.
// - rising enable makes a low-to-high result edge set the irq flag.
// - falling enable makes a high-to-low result edge set the irq flag.
// - 3-bit positive channel field is passed to the analog mux.
// - 3-bit negative channel field is passed to the analog mux.
// - mirror register holds results 3..0 in bits 3..0, upper bits zero.
// - port reads return zero for pins configured as analog inputs.
// - filter blocks reversal of an output change for a nominal 20 ns.
// - software clears the flag; an edge during the clear leaves it set.
// - toggling invert changes result; toggling enable changes it only while the raw compare is 1; either may set the flag.
// - sync latch samples on the prescaled timer clock.
`ifndef CMPDC_REGS_VH
`define CMPDC_REGS_VH
`define CMPDC_NUM 4
`define CMPDC_CTRL0_BASE 12'h000
`define CMPDC_CTRL1_BASE 12'h010
`define CMPDC_MIRROR_ADDR 12'h020
`define CMPDC_FLAG_ADDR 12'h024
`define CMPDC_PORT_ADDR 12'h028
`define CMPDC_STRIDE 4
`define CMPDC_PCH_MSB 5
`define CMPDC_PCH_LSB 3
`define CMPDC_NCH_MSB 2
`define CMPDC_NCH_LSB 0
`define CMPDC_B_ENABLE 7
`define CMPDC_B_RESULT 6
`define CMPDC_B_OE 5
`define CMPDC_B_INVERT 4
`define CMPDC_B_FILTER 3
`define CMPDC_B_SPEED 2
`define CMPDC_B_HYST 1
`define CMPDC_B_SYNC 0
`define CMPDC_B_RISE 7
`define CMPDC_B_FALL 6
`define CMPDC_CTRL0_RESET 8'h04
`define CMPDC_CTRL1_RESET 8'h00
`define CMPDC_CTRL0_WMASK 8'hbf
`define CMPDC_FILTER_NS 20
`define CMPDC_CLK_MHZ 100
`define CMPDC_FILTER_CYC ((`CMPDC_FILTER_NS * `CMPDC_CLK_MHZ) / 1000)
`define CMPDC_RESP_OKAY 2'b00
`define CMPDC_RESP_SLVERR 2'b10
`endif

/* File: hw/cmpdc_channel.v */
`timescale 1ns/100ps
`include "cmpdc_regs.vh"
module cmpdc_channel #(
  parameter FILTER_CYC = `CMPDC_FILTER_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire raw_compare,
  input wire cmp_enable,
  input wire cmp_invert,
  input wire glitch_filter_enable,
  input wire timer_sync_enable,
  input wire timer_clk_prescaled,
  output reg cmp_result,
  output reg cmp_out
);
  reg pol_q;
  reg filt;
  reg [7:0] hold;
  reg tclk_q;
  reg sync_q;
  wire pol = (cmp_enable & raw_compare) ^ cmp_invert;
  wire after_filt = glitch_filter_enable ? filt : pol;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pol_q <= 1'b0;
      filt <= 1'b0;
      hold <= 8'h00;
      tclk_q <= 1'b0;
      sync_q <= 1'b0;
      cmp_result <= 1'b0;
      cmp_out <= 1'b0;
    end else begin
      pol_q <= pol;
      if (hold != 8'h00) begin
        hold <= hold - 8'h01;
      end else if (pol_q != filt) begin
        filt <= pol_q;
        hold <= FILTER_CYC[7:0] - 8'h01;
      end
      tclk_q <= timer_clk_prescaled;
      if (tclk_q && !timer_clk_prescaled) begin
        sync_q <= after_filt;
      end
      cmp_result <= after_filt;
      cmp_out <= timer_sync_enable ? sync_q : after_filt;
    end
  end
endmodule

/* File: tb/cmpdc_sva.sv */
`timescale 1ns/100ps
module cmpdc_sva #(parameter N = 4) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [N-1:0] pin_direction_bit,
  input wire [N-1:0] cmp_pin_oe,
  input wire [N-1:0] cmp_pin_out,
  input wire [N-1:0] cmp_timer_out,
  input wire [N-1:0] core_speed,
  input wire [N-1:0] cmp_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_RESP: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_RD_RESP: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response late");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  AST_SPEED_RST: assert property ($rose(aresetn) |-> &core_speed)
    else $error("speed select not set after reset");
  AST_OE_DIR: assert property (!(|(cmp_pin_oe & $past(pin_direction_bit)
    & $past(pin_direction_bit, 2))))
    else $error("pin driven while direction is input");
  AST_SYNC_PAIR: assert property (cmp_timer_out == cmp_pin_out)
    else $error("timer output differs from pin");
  AST_IRQ_HOLD: assert property (|(~cmp_irq & $past(cmp_irq))
    |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("flag dropped without a write");
endmodule
bind cmpdc_top cmpdc_sva #(.N(N)) u_sva (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .pin_direction_bit(pin_direction_bit),
  .cmp_pin_oe(cmp_pin_oe),
  .cmp_pin_out(cmp_pin_out),
  .cmp_timer_out(cmp_timer_out),
  .core_speed(core_speed),
  .cmp_irq(cmp_irq)
);

/* File: tb/cmpdc_analog.sv */
`timescale 1ns/100ps
module cmpdc_analog (
  input wire aclk,
  input wire [3:0] vp_above,
  input wire tmr_run,
  output reg [3:0] raw_compare = 4'h0,
  output reg timer_clk_prescaled = 1'b1
);
  reg [1:0] div = 2'h0;
  always @(posedge aclk) begin
    raw_compare <= vp_above;
    if (tmr_run) begin
      div <= div + 2'h1;
      if (div == 2'h3)
        timer_clk_prescaled <= ~timer_clk_prescaled;
    end
  end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  reg aclk = 1'b0, aresetn = 1'b0, tmr_run = 1'b0;
  reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [31:0] s_axi_wdata = 32'h0, rv;
  reg [3:0] s_axi_wstrb = 4'hf, vp_above = 4'h0, pin_direction_bit = 4'hf;
  reg [7:0] port_pin_level = 8'hff, port_analog_select = 8'h0f;
  reg [1:0] resp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire timer_clk_prescaled;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] raw_compare, cmp_pin_out, cmp_pin_oe, cmp_timer_out;
  wire [3:0] core_enable, core_speed, core_hysteresis, cmp_irq;
  wire [11:0] positive_channel_select, negative_channel_select;
  integer err_count = 0, samples_checked = 0, k, hi;
  always #5 aclk = ~aclk;
  cmpdc_analog u_analog (.*);
  cmpdc_top uut (.*);
  task chk(input string what, input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task rd(input [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task t_reset;
    for (k = 0; k < 4; k = k + 1) begin
      rd({k[9:0], 2'b00});
      chk("ctrl0", rv, 32'h4);
      rd({k[9:0], 2'b00} + 12'h010);
      chk("ctrl1", rv, 32'h0);
    end
    chk("speed", core_speed, 4'hf);
    rd(12'h020);
    chk("mirror", rv, 32'h0);
  endtask
  task t_ctrl;
    pin_direction_bit <= 4'he;
    wr(12'h000, 8'hfe);
    repeat (6) @(posedge aclk);
    rd(12'h000);
    chk("ctrl0", rv, 32'hfe);
    chk("enable", core_enable, 4'h1);
    chk("hyst", core_hysteresis, 4'h1);
    chk("oe", cmp_pin_oe, 4'h1);
    chk("pin", cmp_pin_out, 4'h1);
    wr(12'h000, 8'h20);
    repeat (6) @(posedge aclk);
    chk("enable", core_enable, 4'h0);
    chk("speed", core_speed, 4'he);
    chk("oe", cmp_pin_oe, 4'h1);
    pin_direction_bit <= 4'hf;
    repeat (4) @(posedge aclk);
    chk("oe", cmp_pin_oe, 4'h0);
  endtask
  task t_pol;
    vp_above <= 4'h2;
    wr(12'h004, 8'h80);
    repeat (6) @(posedge aclk);
    rd(12'h004);
    chk("ctrl0", rv, 32'hc0);
    rd(12'h020);
    chk("mirror", rv, 32'h2);
    wr(12'h004, 8'h90);
    repeat (6) @(posedge aclk);
    rd(12'h004);
    chk("ctrl0", rv, 32'h90);
  endtask
  task edge_chk(input [3:0] v, input e);
    vp_above <= v;
    repeat (8) @(posedge aclk);
    chk("irq2", cmp_irq[2], e);
  endtask
  task t_irq;
    wr(12'h008, 8'h80);
    wr(12'h018, 8'h80);
    edge_chk(4'h6, 1'b1);
    wr(12'h024, 8'h04);
    repeat (2) @(posedge aclk);
    chk("irq2", cmp_irq[2], 1'b0);
    edge_chk(4'h2, 1'b0);
    wr(12'h018, 8'h40);
    edge_chk(4'h6, 1'b0);
    edge_chk(4'h2, 1'b1);
    wr(12'h01c, 8'h80);
    wr(12'h00c, 8'h10);
    repeat (8) @(posedge aclk);
    chk("irq3", cmp_irq[3], 1'b1);
  endtask
  task t_misc;
    wr(12'h014, 8'h2b);
    repeat (2) @(posedge aclk);
    chk("pch", positive_channel_select[5:3], 3'h5);
    chk("nch", negative_channel_select[5:3], 3'h3);
    rd(12'h028);
    chk("port", rv, 32'hf0);
    rd(12'h100);
    chk("rresp", resp, 2'h2);
    wr(12'h100, 8'hff);
    chk("bresp", resp, 2'h2);
  endtask
  task t_sync;
    pin_direction_bit <= 4'he;
    vp_above <= 4'h0;
    wr(12'h000, 8'ha1);
    vp_above <= 4'h1;
    repeat (8) @(posedge aclk);
    chk("pin", cmp_pin_out[0], 1'b0);
    tmr_run <= 1'b1;
    repeat (12) @(posedge aclk);
    chk("pin", cmp_pin_out[0], 1'b1);
    chk("timer", cmp_timer_out[0], 1'b1);
  endtask
  task pulse_chk(input [7:0] c, input [31:0] n);
    wr(12'h004, c);
    repeat (4) @(posedge aclk);
    vp_above <= 4'h3;
    @(posedge aclk);
    vp_above <= 4'h1;
    hi = 0;
    repeat (10) begin
      @(posedge aclk);
      if (cmp_pin_out[1] === 1'b1) hi = hi + 1;
    end
    chk("pulse", hi, n);
  endtask
  task t_filt;
    pulse_chk(8'h88, 32'h0000_0002);
    pulse_chk(8'h80, 32'h0000_0001);
  endtask
  task close_out;
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_count = err_count + 1;
    close_out;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_ctrl;
    t_pol;
    t_irq;
    t_misc;
    t_sync;
    t_filt;
    close_out;
  end
endmodule
